/* inc/pnm_regs.svh */
// Constants of the phase 2 nibble map: byte store slots, nibble numbers and encodings.
// Notes on behaviour
// (RULE1) Nibbles D19 and D20 carry serial byte 4 upper then lower, or the upper halves of user bytes six and fourteen, as the select bit says.
// (RULE2) Page 2 addresses 0000 and 0001 carry channel 0's positive self-test average, upper half first.
// (RULE3) Page 2 addresses 0010 and 0011 carry channel 0's offset after positive self-test, upper half first.
// (RULE4) Page 2 addresses 0100 and 0101 carry channel 0's negative self-test average, upper half first.
// (RULE5) Page 2 addresses 0110 and 0111 carry channel 0's offset after negative self-test, upper half first.
// (RULE6) Page 2 addresses 1000 and 1001 carry channel 1's positive self-test average, upper half first.
// (RULE7) Page 2 addresses 1010 and 1011 carry channel 1's offset after positive self-test, upper half first.
// (RULE8) Page 2 addresses 1100 and 1101 carry channel 1's negative self-test average, upper half first.
// (RULE9) Page 2 address 1110 carries the upper half of channel 1's offset after negative self-test.
// (RULE10) Page 2 address 1111 carries the lower half of that offset and is D48, the final nibble.
// (RULE11) D21 to D28 carry serial bytes 3 down to 0 upper half first, then part byte 1 low, byte 0 high, byte 0 low.
// (RULE12) Page 1 address 1111 carries the upper half of user byte six.
// (RULE13) The sequence ends at D32 normally and runs on to D48 when the extended length option is set.
// (RULE14) Each nibble goes out as an identifier frame then a value frame, the pair repeated k times, once when k is 0.
// (RULE15) Each channel sends its own content; this map is channel 0's.
`ifndef PNM_REGS_SVH
`define PNM_REGS_SVH

`define PNM_SLOT_SN4 5'h00
`define PNM_SLOT_SN3 5'h01
`define PNM_SLOT_PN1 5'h05
`define PNM_SLOT_PN0 5'h06
`define PNM_SLOT_UD6 5'h07
`define PNM_SLOT_UD14 5'h08
`define PNM_SLOT_C0PA 5'h09
`define PNM_SLOT_COUNT 5'h11
`define PNM_SLOT_LAST 5'h10

`define PNM_NIB_FIRST 6'h13
`define PNM_NIB_D20 6'h14
`define PNM_NIB_D21 6'h15
`define PNM_NIB_D29 6'h1d
`define PNM_NIB_D30 6'h1e
`define PNM_NIB_D31 6'h1f
`define PNM_NIB_LAST_NORMAL 6'h20
`define PNM_NIB_PAGE2 6'h21
`define PNM_NIB_LAST_EXT 6'h30

`define PNM_SEL_SERIAL 1'b1

`endif

/* inc/pnm_pkg.sv */
// Types shared by the phase 2 nibble map, its receiver model and its bench.
package pnm_pkg;

	typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_RUN} pnm_state_t;

	// Source bytes; the first field is store slot 0.
	typedef struct packed {
		logic [7:0] serial_number_byte4;
		logic [7:0] serial_number_byte3;
		logic [7:0] serial_number_byte2;
		logic [7:0] serial_number_byte1;
		logic [7:0] serial_number_byte0;
		logic [7:0] part_number_byte1;
		logic [7:0] part_number_byte0;
		logic [7:0] user_byte_six;
		logic [7:0] user_byte_fourteen;
		logic [7:0] chan0_selftest_pos_average;
		logic [7:0] chan0_post_pos_selftest_offset;
		logic [7:0] chan0_selftest_neg_average;
		logic [7:0] chan0_post_neg_selftest_offset;
		logic [7:0] chan1_selftest_pos_average;
		logic [7:0] chan1_post_pos_selftest_offset;
		logic [7:0] chan1_selftest_neg_average;
		logic [7:0] chan1_post_neg_selftest_offset;
	} pnm_src_t;

	typedef struct packed {
		logic phase2_nibble19_source_select;
		logic phase2_extended_length;
		logic [3:0] rep_count;
	} pnm_cfg_t;

	typedef struct packed {
		logic valid;
		logic is_id;
		logic [3:0] value;
		logic [5:0] num;
		logic [1:0] page;
		logic [3:0] addr;
	} pnm_tx_t;

	typedef struct packed {
		pnm_state_t st;
		logic [4:0] slot;
		logic [5:0] nib;
		logic [3:0] rep;
		logic is_data;
		pnm_cfg_t cfg;
		pnm_tx_t tx;
		logic busy;
		logic done;
	} pnm_core_t;

endpackage : pnm_pkg

/* logic/pnm_byte_store.sv */
// Small byte store with one write port and a registered read port.
`timescale 1ns/1ps
module pnm_byte_store #(
	parameter int DEPTH = 17,
	parameter int AW = 5
) (
	input wire logic clk_i, // System clock.
	input wire logic we_i, // Write enable.
	input wire logic [AW-1:0] waddr_i, // Write slot.
	input wire logic [7:0] wdata_i, // Write byte.
	input wire logic [AW-1:0] raddr_i, // Read slot.
	output logic [7:0] rdata_o // Registered read byte.
);

	logic [7:0] mem [DEPTH];

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end

endmodule : pnm_byte_store

/* logic/pnm_init2_map.sv */
// Channel 0 phase 2 sequencer and content map for nibbles D19 to D48.
`timescale 1ns/1ps
`include "pnm_regs.svh"
module pnm_init2_map
	import pnm_pkg::*;
#(
	parameter int DEPTH = 17
) (
	input wire logic clk_i, // System clock, 25 MHz.
	input wire logic rst_i, // Asynchronous reset, active high.
	input wire logic start_i, // Pulse: snapshot sources and begin at D19.
	input wire logic slot_tick_i, // Pulse: one transmission slot.
	input wire pnm_cfg_t cfg_i, // Select bit, extended length, k.
	input wire pnm_src_t src_i, // Source bytes.
	output pnm_tx_t tx_o, // Transmission for this slot.
	output logic busy_o, // High from start to the end of D32 or D48.
	output logic done_o // Pulse in the same cycle as the last value frame.
);

	// ************************************************************
	// Content map
	// ************************************************************

	// Returns the store slot and, in bit 0, whether the upper half is sent.
	// (RULE15) Channel 0 mapping only.
	function automatic logic [5:0] nib_map(input logic [5:0] n, input logic sel);
		logic [5:0] d;
		logic [4:0] slot;
		logic upper;
		d = 6'h00;
		slot = `PNM_SLOT_SN4;
		upper = 1'b1;
		case (n)
			// (RULE1) D19 and D20 source.
			`PNM_NIB_FIRST: begin
				slot = (sel == `PNM_SEL_SERIAL) ? `PNM_SLOT_SN4 : `PNM_SLOT_UD6;
				upper = 1'b1;
			end
			`PNM_NIB_D20: begin
				slot = (sel == `PNM_SEL_SERIAL) ? `PNM_SLOT_SN4 : `PNM_SLOT_UD14;
				upper = (sel != `PNM_SEL_SERIAL);
			end
			// (RULE11) Part number halves.
			`PNM_NIB_D29: begin
				slot = `PNM_SLOT_PN1;
				upper = 1'b0;
			end
			`PNM_NIB_D30: begin
				slot = `PNM_SLOT_PN0;
				upper = 1'b1;
			end
			`PNM_NIB_D31: begin
				slot = `PNM_SLOT_PN0;
				upper = 1'b0;
			end
			// (RULE12) User byte six upper half.
			`PNM_NIB_LAST_NORMAL: begin
				slot = `PNM_SLOT_UD6;
				upper = 1'b1;
			end
			default: begin
				// (RULE2) (RULE3) (RULE4) (RULE5) Channel 0 self-test pairs.
				// (RULE6) (RULE7) (RULE8) (RULE9) (RULE10) Channel 1 pairs.
				if (n >= `PNM_NIB_PAGE2) begin
					d = n - `PNM_NIB_PAGE2;
					slot = `PNM_SLOT_C0PA + d[5:1];
				end else begin
					// (RULE11) Serial bytes 3 down to 0.
					d = n - `PNM_NIB_D21;
					slot = `PNM_SLOT_SN3 + d[5:1];
				end
				upper = n[0];
			end
		endcase
		return {slot, upper};
	endfunction : nib_map

	// ************************************************************
	// Source snapshot store
	// ************************************************************

	pnm_core_t s;
	pnm_core_t next_s;
	logic [5:0] map_q;
	logic [7:0] rd_byte;
	logic [7:0] wr_byte;
	logic [DEPTH*8-1:0] src_vec;

	assign src_vec = src_i;
	assign map_q = nib_map(s.nib, s.cfg.phase2_nibble19_source_select);
	assign wr_byte = src_vec[(DEPTH-1-int'(s.slot))*8 +: 8];

	pnm_byte_store #(
		.DEPTH(DEPTH),
		.AW(5)
	) pnm_byte_store_i (
		.clk_i(clk_i),
		.we_i(s.st == ST_LOAD),
		.waddr_i(s.slot),
		.wdata_i(wr_byte),
		.raddr_i(map_q[5:1]),
		.rdata_o(rd_byte)
	);

	// ************************************************************
	// Sequencer
	// ************************************************************

	always_comb begin
		next_s = s;
		next_s.tx.valid = 1'b0;
		next_s.done = 1'b0;
		case (s.st)
			ST_IDLE: begin
				if (start_i) begin
					next_s.st = ST_LOAD;
					next_s.slot = 5'h00;
					next_s.cfg = cfg_i;
					next_s.busy = 1'b1;
				end
			end
			ST_LOAD: begin
				if (s.slot == `PNM_SLOT_LAST) begin
					next_s.st = ST_RUN;
					next_s.nib = `PNM_NIB_FIRST;
					next_s.rep = 4'h0;
					next_s.is_data = 1'b0;
				end else begin
					next_s.slot = s.slot + 5'h01;
				end
			end
			ST_RUN: begin
				if (slot_tick_i) begin
					next_s.tx.valid = 1'b1;
					next_s.tx.num = s.nib;
					next_s.tx.page = 2'(s.nib - 6'h01 >> 4);
					next_s.tx.addr = 4'(s.nib - 6'h01);
					// (RULE14) Identifier frame, then value frame.
					if (!s.is_data) begin
						next_s.tx.is_id = 1'b1;
						next_s.tx.value = 4'(s.nib - 6'h01);
						next_s.is_data = 1'b1;
					end else begin
						next_s.tx.is_id = 1'b0;
						next_s.tx.value = map_q[0] ? rd_byte[7:4] : rd_byte[3:0];
						next_s.is_data = 1'b0;
						next_s.rep = s.rep + 4'h1;
						// (RULE14) Pair repeated k times, once when k is 0.
						if (s.rep + 4'h1 >= s.cfg.rep_count) begin
							next_s.rep = 4'h0;
							// (RULE13) Last nibble depends on length.
							if (s.nib == (s.cfg.phase2_extended_length ?
								`PNM_NIB_LAST_EXT : `PNM_NIB_LAST_NORMAL)) begin
								next_s.st = ST_IDLE;
								next_s.busy = 1'b0;
								next_s.done = 1'b1;
							end else begin
								next_s.nib = s.nib + 6'h01;
							end
						end
					end
				end
			end
			default: begin
				next_s.st = ST_IDLE;
				next_s.busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tx_o = s.tx;
	assign busy_o = s.busy;
	assign done_o = s.done;

	// ************************************************************
	// Checks
	// ************************************************************

	// Sources must not move during a run for the content checks to hold.
	pnm_src_t src_prev;
	logic src_moved;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			src_prev <= '0;
			src_moved <= 1'b0;
		end else begin
			src_prev <= src_i;
			if (s.st == ST_IDLE) begin
				src_moved <= 1'b0;
			end else if (src_i != src_prev) begin
				src_moved <= 1'b1;
			end
		end
	end

	logic vd;
	assign vd = tx_o.valid && !tx_o.is_id && !src_moved;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	d19_select_a: assert property (vd && tx_o.num == 6'h13 |-> // RULE1
		tx_o.value == (s.cfg.phase2_nibble19_source_select ?
		src_i.serial_number_byte4[7:4] : src_i.user_byte_six[7:4]))
		else $error("D19 content wrong");
	d20_select_a: assert property (vd && tx_o.num == 6'h14 |-> // RULE1
		tx_o.value == (s.cfg.phase2_nibble19_source_select ?
		src_i.serial_number_byte4[3:0] : src_i.user_byte_fourteen[7:4]))
		else $error("D20 content wrong");
	ch0_pos_avg_a: assert property (vd && tx_o.num == 6'h22 |-> // RULE2
		tx_o.value == src_i.chan0_selftest_pos_average[3:0] && tx_o.page == 2'h2
		&& tx_o.addr == 4'h1) else $error("D34 content wrong");
	ch0_pos_off_a: assert property (vd && tx_o.num == 6'h23 |-> // RULE3
		tx_o.value == src_i.chan0_post_pos_selftest_offset[7:4])
		else $error("D35 content wrong");
	ch0_neg_avg_a: assert property (vd && tx_o.num == 6'h25 |-> // RULE4
		tx_o.value == src_i.chan0_selftest_neg_average[7:4])
		else $error("D37 content wrong");
	ch0_neg_off_a: assert property (vd && tx_o.num == 6'h28 |-> // RULE5
		tx_o.value == src_i.chan0_post_neg_selftest_offset[3:0])
		else $error("D40 content wrong");
	ch1_pos_avg_a: assert property (vd && tx_o.num == 6'h29 |-> // RULE6
		tx_o.value == src_i.chan1_selftest_pos_average[7:4])
		else $error("D41 content wrong");
	ch1_pos_off_a: assert property (vd && tx_o.num == 6'h2c |-> // RULE7
		tx_o.value == src_i.chan1_post_pos_selftest_offset[3:0])
		else $error("D44 content wrong");
	ch1_neg_avg_a: assert property (vd && tx_o.num == 6'h2d |-> // RULE8
		tx_o.value == src_i.chan1_selftest_neg_average[7:4])
		else $error("D45 content wrong");
	ch1_off_hi_a: assert property (vd && tx_o.num == 6'h2f |-> // RULE9
		tx_o.value == src_i.chan1_post_neg_selftest_offset[7:4] && tx_o.addr == 4'he)
		else $error("D47 content wrong");
	ch1_off_lo_a: assert property (vd && tx_o.num == 6'h30 |-> // RULE10
		tx_o.value == src_i.chan1_post_neg_selftest_offset[3:0] && tx_o.addr == 4'hf)
		else $error("D48 content wrong");
	serial_part_a: assert property (vd && tx_o.num == 6'h1d |-> // RULE11
		tx_o.value == src_i.part_number_byte1[3:0] && $past(src_moved) == 1'b0)
		else $error("D29 content wrong");
	serial_byte3_a: assert property (vd && tx_o.num == 6'h15 |-> // RULE11
		tx_o.value == src_i.serial_number_byte3[7:4]) else $error("D21 content wrong");
	user_six_a: assert property (vd && tx_o.num == 6'h20 |-> // RULE12
		tx_o.value == src_i.user_byte_six[7:4] && tx_o.page == 2'h1)
		else $error("D32 content wrong");
	short_length_a: assert property (tx_o.valid && !s.cfg.phase2_extended_length |-> // RULE13
		tx_o.num <= 6'h20) else $error("Nibble beyond D32 in normal length");
	end_done_a: assert property (done_o |-> $past(tx_o.num) == // RULE13
		(s.cfg.phase2_extended_length ? 6'h30 : 6'h20) && !busy_o)
		else $error("Sequence ended on wrong nibble");
	id_then_val_a: assert property (tx_o.valid && tx_o.is_id |=> // RULE14
		!(tx_o.valid && tx_o.is_id) until (tx_o.valid && !tx_o.is_id))
		else $error("Two identifier frames in a row");
	chan_own_a: assert property (vd && tx_o.num == 6'h21 |-> // RULE15
		tx_o.value == src_i.chan0_selftest_pos_average[7:4])
		else $error("D33 not channel 0 content");

	// Remaining nibble contents except D23 and D26 against the live sources.
	d22_serial_a: assert property (vd && tx_o.num == 6'h16 |-> // RULE11
		tx_o.value == src_i.serial_number_byte3[3:0]) else $error("D22 content wrong");
	d24_serial_a: assert property (vd && tx_o.num == 6'h18 |-> // RULE11
		tx_o.value == src_i.serial_number_byte2[3:0]) else $error("D24 content wrong");
	d25_serial_a: assert property (vd && tx_o.num == 6'h19 |-> // RULE11
		tx_o.value == src_i.serial_number_byte1[7:4]) else $error("D25 content wrong");
	d27_serial_a: assert property (vd && tx_o.num == 6'h1b |-> // RULE11
		tx_o.value == src_i.serial_number_byte0[7:4]) else $error("D27 content wrong");
	d28_serial_a: assert property (vd && tx_o.num == 6'h1c |-> // RULE11
		tx_o.value == src_i.serial_number_byte0[3:0]) else $error("D28 content wrong");
	d30_part_a: assert property (vd && tx_o.num == 6'h1e |-> // RULE11
		tx_o.value == src_i.part_number_byte0[7:4]) else $error("D30 content wrong");
	d31_part_a: assert property (vd && tx_o.num == 6'h1f |-> // RULE11
		tx_o.value == src_i.part_number_byte0[3:0]) else $error("D31 content wrong");
	d36_pos_off_a: assert property (vd && tx_o.num == 6'h24 |-> // RULE3
		tx_o.value == src_i.chan0_post_pos_selftest_offset[3:0])
		else $error("D36 content wrong");
	d38_neg_avg_a: assert property (vd && tx_o.num == 6'h26 |-> // RULE4
		tx_o.value == src_i.chan0_selftest_neg_average[3:0])
		else $error("D38 content wrong");
	d39_neg_off_a: assert property (vd && tx_o.num == 6'h27 |-> // RULE5
		tx_o.value == src_i.chan0_post_neg_selftest_offset[7:4])
		else $error("D39 content wrong");
	d42_pos_avg_a: assert property (vd && tx_o.num == 6'h2a |-> // RULE6
		tx_o.value == src_i.chan1_selftest_pos_average[3:0])
		else $error("D42 content wrong");
	d43_pos_off_a: assert property (vd && tx_o.num == 6'h2b |-> // RULE7
		tx_o.value == src_i.chan1_post_pos_selftest_offset[7:4])
		else $error("D43 content wrong");
	d46_neg_avg_a: assert property (vd && tx_o.num == 6'h2e |-> // RULE8
		tx_o.value == src_i.chan1_selftest_neg_average[3:0])
		else $error("D46 content wrong");

	// Framing and handshake.
	id_value_a: assert property (tx_o.valid && tx_o.is_id |-> // RULE14
		tx_o.value == tx_o.addr) else $error("Identifier frame value is not the address");
	addr_page_a: assert property (tx_o.valid |-> // RULE10
		tx_o.addr == 4'(tx_o.num - 6'h01) && tx_o.page == 2'((tx_o.num - 6'h01) >> 4))
		else $error("Page or address does not match nibble number");
	tick_answer_a: assert property (slot_tick_i && s.st == ST_RUN |=> tx_o.valid) // RULE14
		else $error("Slot in run gave no frame");
	load_quiet_a: assert property (s.st == ST_LOAD |=> !tx_o.valid) // RULE14
		else $error("Frame sent while loading");
	start_busy_a: assert property (start_i && !busy_o |=> busy_o) // RULE13
		else $error("Accepted start did not raise busy");
	done_pulse_a: assert property (done_o |=> !done_o) // RULE13
		else $error("Done longer than one cycle");

	run_ext_c: cover property (done_o && s.cfg.phase2_extended_length);
	run_short_c: cover property (done_o && !s.cfg.phase2_extended_length);
	sel_user_c: cover property (vd && tx_o.num == 6'h14 &&
		!s.cfg.phase2_nibble19_source_select);
	sel_serial_c: cover property (vd && tx_o.num == 6'h13 &&
		s.cfg.phase2_nibble19_source_select);
	rep_multi_c: cover property (done_o && s.cfg.rep_count > 4'h1);

endmodule : pnm_init2_map

/* testbench/pnm_rx_model.sv */
// Receiver model that paces transmission slots and checks frame pairing.
`timescale 1ns/1ps
module pnm_rx_model
	import pnm_pkg::*;
(
	input wire logic clk_i, // System clock.
	input wire logic rst_i, // Asynchronous reset, active high.
	input wire logic en_i, // Slots are issued while high.
	input wire logic [3:0] gap_i, // Cycles between slots, two or more.
	input wire pnm_tx_t tx_i, // Frames from the map.
	output logic slot_tick_o, // One cycle slot pulse.
	output logic pair_err_o // Set when frames fall out of step.
);
	logic [3:0] cnt;
	logic want_id;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt <= 4'h0;
			slot_tick_o <= 1'b0;
			pair_err_o <= 1'b0;
			want_id <= 1'b1;
		end else begin
			slot_tick_o <= 1'b0;
			if (!en_i) begin
				cnt <= 4'h0;
			end else if (cnt >= gap_i - 4'h1) begin
				cnt <= 4'h0;
				slot_tick_o <= 1'b1;
			end else begin
				cnt <= cnt + 4'h1;
			end
			if (tx_i.valid === 1'b1) begin
				if (tx_i.is_id !== want_id) begin
					pair_err_o <= 1'b1;
				end
				want_id <= ~tx_i.is_id;
			end
		end
	end
endmodule : pnm_rx_model

/* testbench/pnm_init2_map_tb.sv */
// Self-checking bench for the phase 2 nibble map.
`timescale 1ns/1ps
module pnm_init2_map_tb
	import pnm_pkg::*;
;
	logic clk_i;
	logic rst_i;
	logic start_i;
	logic en;
	logic [3:0] gap;
	pnm_cfg_t cfg_i;
	pnm_src_t src_i;
	pnm_tx_t tx_o;
	logic busy_o;
	logic done_o;
	logic tick;
	logic pair_err;
	logic [16:0] q[$];
	int n_fail = 0;
	int checked = 0;
	int cycles = 0;
	int seed = 32'h326b;

	pnm_init2_map pnm_init2_map_i (.clk_i(clk_i), .rst_i(rst_i), .start_i(start_i),
		.slot_tick_i(tick), .cfg_i(cfg_i), .src_i(src_i), .tx_o(tx_o), .busy_o(busy_o),
		.done_o(done_o));
	pnm_rx_model pnm_rx_model_i (.clk_i(clk_i), .rst_i(rst_i), .en_i(en), .gap_i(gap),
		.tx_i(tx_o), .slot_tick_o(tick), .pair_err_o(pair_err));

	// ****************
	// Helpers
	// ****************
	task chk(input string nm, input logic [16:0] seen, input logic [16:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task summarize();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : summarize

	function logic [3:0] exp_nib(input pnm_src_t s, input logic sel, input int n);
		logic [31:0] sn;
		logic [63:0] st;
		sn = {s.serial_number_byte3, s.serial_number_byte2, s.serial_number_byte1,
			s.serial_number_byte0};
		st = {s.chan0_selftest_pos_average, s.chan0_post_pos_selftest_offset,
			s.chan0_selftest_neg_average, s.chan0_post_neg_selftest_offset,
			s.chan1_selftest_pos_average, s.chan1_post_pos_selftest_offset,
			s.chan1_selftest_neg_average, s.chan1_post_neg_selftest_offset};
		if (n == 19) return sel ? s.serial_number_byte4[7:4] : s.user_byte_six[7:4];
		if (n == 20) return sel ? s.serial_number_byte4[3:0] : s.user_byte_fourteen[7:4];
		if (n <= 28) return sn[31 - 4 * (n - 21) -: 4];
		if (n == 29) return s.part_number_byte1[3:0];
		if (n == 30) return s.part_number_byte0[7:4];
		if (n == 31) return s.part_number_byte0[3:0];
		if (n == 32) return s.user_byte_six[7:4];
		return st[63 - 4 * (n - 33) -: 4];
	endfunction : exp_nib

	task run_case(input logic sel, input logic ext, input logic [3:0] k, input logic [3:0] g);
		int kk;
		int i;
		logic [3:0] a;
		logic [1:0] pg;
		logic [159:0] r;
		pnm_src_t s;
		r = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
		s = r[135:0];
		kk = (k == 4'h0) ? 1 : int'(k);
		for (int n = 19; n <= (ext ? 48 : 32); n++) begin
			a = 4'(n - 1);
			pg = 2'((n - 1) >> 4);
			for (int j = 0; j < kk; j++) begin
				q.push_back({1'b1, a, 6'(n), pg, a});
				q.push_back({1'b0, exp_nib(s, sel, n), 6'(n), pg, a});
			end
		end
		@(posedge clk_i);
		src_i <= s;
		gap <= g;
		cfg_i <= {sel, ext, k};
		start_i <= 1'b1;
		en <= 1'b1;
		@(posedge clk_i);
		cfg_i <= ~{sel, ext, k};
		@(posedge clk_i);
		start_i <= 1'b0;
		chk("busy_run", 17'(busy_o), 17'h1);
		for (i = 0; i < 5000 && done_o !== 1'b1; i++) @(posedge clk_i);
		chk("done_seen", 17'(i < 5000), 17'h1);
		en <= 1'b0;
		@(posedge clk_i);
		chk("frames_left", 17'(q.size()), 17'h0);
		chk("pairing", 17'(pair_err), 17'h0);
		$display("case sel %0b ext %0b k %0d done", sel, ext, k);
	endtask : run_case

	// ****************
	// Frame monitor
	// ****************
	always @(posedge clk_i) begin
		if (tx_o.valid === 1'b1) begin
			if (q.size() == 0) begin
				chk("extra_frame", 17'h1, 17'h0);
			end else begin
				chk("frame", tx_o[16:0], q.pop_front());
			end
		end
		if (done_o === 1'b1) begin
			chk("busy_at_done", 17'(busy_o), 17'h0);
		end
	end

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			summarize();
		end
	end

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// ****************
	// Main sequence
	// ****************
	initial begin
		rst_i = 1'b1;
		start_i = 1'b0;
		en = 1'b0;
		gap = 4'h2;
		cfg_i = '0;
		src_i = '0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		chk("reset_out", {tx_o[16:0]}, 17'h0);
		chk("reset_busy", 17'(busy_o), 17'h0);
		run_case(1'b1, 1'b0, 4'h1, 4'h2);
		run_case(1'b0, 1'b1, 4'h2, 4'h5);
		run_case(1'b1, 1'b1, 4'h0, 4'h3);
		run_case(1'b0, 1'b0, 4'h3, 4'h2);
		summarize();
	end
endmodule : pnm_init2_map_tb
